// *** src/gcif_pkg.sv ***
package gcif_pkg;

   // Register offsets on the host byte bus
   localparam logic [7:0] chip_id_power_control_addr      = 8'h00;
   localparam logic [7:0] probe_and_aux_clock_select_addr = 8'h01;
   localparam logic [7:0] timer_interrupt_mask_addr       = 8'h02;
   localparam logic [7:0] alarm_interrupt_mask_addr       = 8'h03;
   localparam logic [7:0] timer_interrupt_flags_addr      = 8'h04;
   localparam logic [7:0] alarm_interrupt_flags_addr      = 8'h05;

   // Field positions in the chip id / power control register
   localparam int power_down_bit    = 0;
   localparam int device_code_lsb   = 1;
   localparam int silicon_rev_lsb   = 4;

   // Field positions in the probe / aux clock register
   localparam int probe_sel_lsb     = 0;
   localparam int aux_rate_lsb      = 6;

   // Reset values
   localparam logic       power_down_reset = 1'b1;
   localparam logic [1:0] aux_rate_reset   = 2'h0;
   localparam logic [5:0] probe_sel_reset  = 6'h00;
   localparam logic [7:0] timer_mask_reset = 8'hff;
   localparam logic [3:0] alarm_mask_reset = 4'hf;

   // Probe source codes: last equalizer register file code and those above it
   localparam logic [5:0] probe_eq_last     = 6'h2f;
   localparam logic [5:0] probe_front_end   = 6'h30;
   localparam logic [5:0] probe_echo        = 6'h31;
   localparam logic [5:0] probe_dfe_sub     = 6'h32;
   localparam logic [5:0] probe_slicer_in   = 6'h33;
   localparam logic [5:0] probe_phase_det   = 6'h34;
   localparam logic [5:0] probe_loop_filter = 6'h35;

   // Aux clock multiplier codes
   typedef enum logic [1:0] {
      aux_x16a = 2'h0,
      aux_x16b = 2'h1,
      aux_x32  = 2'h2,
      aux_x64  = 2'h3
   } aux_rate_t;

   // Alarm flag bit positions
   localparam int alarm_snr_low_bit = 0;
   localparam int alarm_felm_lo_bit = 1;
   localparam int alarm_felm_hi_bit = 2;
   localparam int alarm_sync_bit    = 3;

endpackage : gcif_pkg

// *** src/global_control_and_interrupt_flags.sv ***
// Summary of operation
// - Power-down halts filter processing and forces transmit output to zero.
// - Power-down leaves internal RAM contents untouched.
// - Reset pin or power-on sets the power-down bit.
// - Read-only four-bit silicon revision sits in bits 7..4.
// - Read-only three-bit device code sits in bits 3..1.
// - Two-bit selector picks aux clock: 00/01 x16, 10 x32, 11 x64.
// - Reset forces the aux clock selector to 00.
// - Six-bit probe selector: 0-47 equalizer file, 48-53 internal taps.
// - Mask bit one blocks its flag from the request output.
// - Unmasking a set flag asserts the request output at once.
// - Masking a set flag drops the request unless another flag stands.
// - Timer mask bits align with the eight timer flags.
// - Alarm mask bits 3..0: sync, level high, level low, noise low.
// - Timer flag sets on count one-to-zero, holds until host clears.
// - Host writes zero to clear; steady zero count does not re-set.
// - Request output is active low: any set unmasked flag asserts it.
// - Alarm flag sets on condition; zero write clears if condition ended.
// - Zero write during condition leaves flag set; clears when it ends.
// - Sync condition: detector enabled and accumulation above threshold.
// - Level high above high threshold; level low below low threshold.
// - Noise alarm when meter value exceeds alarm threshold.
`timescale 1ns/1ps
`default_nettype none

module global_control_and_interrupt_flags #(
   parameter logic [3:0] silicon_rev_value = 4'h1, // Arbitrary value
   parameter logic [2:0] device_code_value = 3'h5  // Arbitrary value
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        power_on_detect,
   // Host register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // Timer counts: one-hot is_one / is_zero indications per timer
   input  wire logic [7:0]  timer_count_is_one,
   input  wire logic [7:0]  timer_count_is_zero,
   // Alarm sources
   input  wire logic        sync_detect_enable,
   input  wire logic [15:0] sync_accum,
   input  wire logic [15:0] descrambler_sync_threshold,
   input  wire logic [15:0] far_level_meter,
   input  wire logic [15:0] far_high_threshold,
   input  wire logic [15:0] far_low_threshold,
   input  wire logic [15:0] noise_alarm_meter,
   input  wire logic [15:0] noise_alarm_threshold,
   // Probe sources and the transmit sample
   input  wire logic [15:0] eq_file_data,
   input  wire logic [15:0] front_end_out,
   input  wire logic [15:0] echo_replica,
   input  wire logic [15:0] dfe_sub_out,
   input  wire logic [15:0] slicer_in,
   input  wire logic [15:0] phase_det_out,
   input  wire logic [15:0] loop_filter_out,
   input  wire logic [15:0] tx_sample,
   // Control outputs
   output logic      [5:0]  eq_file_index,
   output logic      [15:0] probe_data,
   output logic      [1:0]  aux_clock_rate,
   output logic      [6:0]  aux_clock_mult,
   output logic             filter_run,
   output logic             ram_hold,
   output logic      [15:0] tx_out,
   output logic             irq_n
);

   ////////////////////////////////////////////////////////////////////////
   // Registers and decode

   logic        power_down_r;
   logic [1:0]  aux_rate_r;
   logic [5:0]  probe_sel_r;
   logic [7:0]  timer_mask_r;
   logic [3:0]  alarm_mask_r;
   logic [7:0]  timer_flags_r;
   logic [7:0]  timer_flags_nxt;
   logic [3:0]  alarm_flags_r;
   logic [3:0]  alarm_flags_nxt;
   logic [7:0]  timer_was_one_r;
   logic [3:0]  alarm_cond;
   logic        wr_chip;
   logic        wr_probe;
   logic        wr_tmask;
   logic        wr_amask;
   logic        wr_tflag;
   logic        wr_aflag;
   logic        por_meta_r;
   logic        por_sync_r;
   logic        init_req;

   assign wr_chip  = reg_wr && reg_addr == gcif_pkg::chip_id_power_control_addr;
   assign wr_probe = reg_wr &&
                     reg_addr == gcif_pkg::probe_and_aux_clock_select_addr;
   assign wr_tmask = reg_wr && reg_addr == gcif_pkg::timer_interrupt_mask_addr;
   assign wr_amask = reg_wr && reg_addr == gcif_pkg::alarm_interrupt_mask_addr;
   assign wr_tflag = reg_wr && reg_addr == gcif_pkg::timer_interrupt_flags_addr;
   assign wr_aflag = reg_wr && reg_addr == gcif_pkg::alarm_interrupt_flags_addr;

   // Power-on detect is an external level, so it is synchronised first
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         por_meta_r <= 1'b0;
         por_sync_r <= 1'b0;
      end else begin
         por_meta_r <= power_on_detect;
         por_sync_r <= por_meta_r;
      end
   end

   assign init_req = reset || por_sync_r;

   ////////////////////////////////////////////////////////////////////////
   // Power-down control

   // Set by reset or power-on; only a zero write releases it
   always_ff @(posedge sys_clk) begin
      if (init_req) begin
         power_down_r <= gcif_pkg::power_down_reset;
      end else if (wr_chip) begin
         power_down_r <= reg_wdata[gcif_pkg::power_down_bit];
      end
   end

   // Filters stop and the line goes quiet while powered down
   assign filter_run = !power_down_r;
   assign ram_hold   = power_down_r;  // RAM is frozen, never cleared

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tx_out <= 16'h0000;
      end else if (power_down_r) begin
         tx_out <= 16'h0000;
      end else begin
         tx_out <= tx_sample;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Probe and aux clock selection

   always_ff @(posedge sys_clk) begin
      if (init_req) begin
         aux_rate_r  <= gcif_pkg::aux_rate_reset;
         probe_sel_r <= gcif_pkg::probe_sel_reset;
      end else if (wr_probe) begin
         aux_rate_r  <= reg_wdata[gcif_pkg::aux_rate_lsb +: 2];
         probe_sel_r <= reg_wdata[gcif_pkg::probe_sel_lsb +: 6];
      end
   end

   assign aux_clock_rate = aux_rate_r;

   // Multiplier of the symbol_clock rate for the aux clock synthesiser
   always_comb begin
      case (gcif_pkg::aux_rate_t'(aux_rate_r))
         gcif_pkg::aux_x32: aux_clock_mult = 7'd32;
         gcif_pkg::aux_x64: aux_clock_mult = 7'd64;
         default:           aux_clock_mult = 7'd16; // Codes 00 and 01
      endcase
   end

   // Codes above 53 are undefined and probe zero
   assign eq_file_index = probe_sel_r;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         probe_data <= 16'h0000;
      end else if (probe_sel_r <= gcif_pkg::probe_eq_last) begin
         probe_data <= eq_file_data;
      end else begin
         case (probe_sel_r)
            gcif_pkg::probe_front_end:   probe_data <= front_end_out;
            gcif_pkg::probe_echo:        probe_data <= echo_replica;
            gcif_pkg::probe_dfe_sub:     probe_data <= dfe_sub_out;
            gcif_pkg::probe_slicer_in:   probe_data <= slicer_in;
            gcif_pkg::probe_phase_det:   probe_data <= phase_det_out;
            gcif_pkg::probe_loop_filter: probe_data <= loop_filter_out;
            default:                     probe_data <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt masks

   // Masks come up set so nothing interrupts before software is ready
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_mask_r <= gcif_pkg::timer_mask_reset;
         alarm_mask_r <= gcif_pkg::alarm_mask_reset;
      end else begin
         if (wr_tmask) begin
            timer_mask_r <= reg_wdata;
         end
         if (wr_amask) begin
            alarm_mask_r <= reg_wdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer flags

   // Remember last cycle's count-of-one to catch the step to zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_was_one_r <= 8'h00;
      end else begin
         timer_was_one_r <= timer_count_is_one;
      end
   end

   // Set beats a clearing write in the same cycle; ones in a write are no-ops
   generate
      for (genvar i = 0; i < 8; i++) begin : g_timer_flag
         always_comb begin
            if (timer_was_one_r[i] && timer_count_is_zero[i]) begin
               timer_flags_nxt[i] = 1'b1;
            end else if (wr_tflag && !reg_wdata[i]) begin
               timer_flags_nxt[i] = 1'b0;
            end else begin
               timer_flags_nxt[i] = timer_flags_r[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_flags_r <= 8'h00;
      end else begin
         timer_flags_r <= timer_flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarm conditions and flags

   always_comb begin
      alarm_cond = 4'h0;
      alarm_cond[gcif_pkg::alarm_sync_bit] = sync_detect_enable &&
         (sync_accum > descrambler_sync_threshold);
      alarm_cond[gcif_pkg::alarm_felm_hi_bit] =
         far_level_meter > far_high_threshold;
      alarm_cond[gcif_pkg::alarm_felm_lo_bit] =
         far_level_meter < far_low_threshold;
      alarm_cond[gcif_pkg::alarm_snr_low_bit] =
         noise_alarm_meter > noise_alarm_threshold;
   end

   // A zero write arms a clear that fires once the condition is gone; the
   // pending state is held in clear_pend_r, and an ended condition clears at once
   logic [3:0] clear_pend_r;

   generate
      for (genvar j = 0; j < 4; j++) begin : g_alarm_flag
         always_comb begin
            if (alarm_cond[j]) begin
               alarm_flags_nxt[j] = 1'b1;
            end else if ((wr_aflag && !reg_wdata[j]) || clear_pend_r[j]) begin
               alarm_flags_nxt[j] = 1'b0;
            end else begin
               alarm_flags_nxt[j] = alarm_flags_r[j];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         alarm_flags_r <= 4'h0;
         clear_pend_r  <= 4'h0;
      end else begin
         alarm_flags_r <= alarm_flags_nxt;
         clear_pend_r  <= (clear_pend_r | ({4{wr_aflag}} & ~reg_wdata[3:0]))
                          & alarm_flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request output and read back

   // Combinational so mask writes act on the very next cycle
   assign irq_n = !(|(timer_flags_r & ~timer_mask_r) ||
                    |(alarm_flags_r & ~alarm_mask_r));

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            gcif_pkg::chip_id_power_control_addr:
               reg_rdata <= {silicon_rev_value, device_code_value,
                             power_down_r};
            gcif_pkg::probe_and_aux_clock_select_addr:
               reg_rdata <= {aux_rate_r, probe_sel_r};
            gcif_pkg::timer_interrupt_mask_addr:  reg_rdata <= timer_mask_r;
            gcif_pkg::alarm_interrupt_mask_addr:
               reg_rdata <= {4'h0, alarm_mask_r};
            gcif_pkg::timer_interrupt_flags_addr: reg_rdata <= timer_flags_r;
            gcif_pkg::alarm_interrupt_flags_addr:
               reg_rdata <= {4'h0, alarm_flags_r};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule : global_control_and_interrupt_flags

`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Host processor on the byte register port
module host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   // Idle bus from time zero, no strobe before reset ends
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   // One-cycle write; a zero data bit clears a flag or power-down
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~v; // Released data must not repeat the last value
   endtask : wr
   // Read data lands on the edge that takes the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      v = reg_rdata;
   endtask : rd
endmodule : host_model
`default_nettype wire

// *** tb/gcif_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gcif_chk (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        power_on_detect,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic [7:0]  timer_count_is_one,
   input wire logic [7:0]  timer_count_is_zero,
   input wire logic [15:0] noise_alarm_meter,
   input wire logic [15:0] noise_alarm_threshold,
   input wire logic [15:0] eq_file_data,
   input wire logic [5:0]  eq_file_index,
   input wire logic [15:0] probe_data,
   input wire logic [1:0]  aux_clock_rate,
   input wire logic [6:0]  aux_clock_mult,
   input wire logic        ram_hold,
   input wire logic [15:0] tx_out,
   input wire logic        irq_n
);
   logic [7:0] tm_r;
   logic [3:0] am_r;
   // Shadow masks from host writes, since the masks are not at the ports
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tm_r <= 8'hff;
         am_r <= 4'hf;
      end else if (reg_wr && reg_addr == 8'h02) begin
         tm_r <= reg_wdata;
      end else if (reg_wr && reg_addr == 8'h03) begin
         am_r <= reg_wdata[3:0];
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Power-on sync stages drained, so it cannot set power-down late
   sequence pod_quiet;
      !power_on_detect [*5];
   endsequence
   sequence tmr_tick;
      |(timer_count_is_one & ~tm_r) ##1
      (|(timer_count_is_zero & $past(timer_count_is_one) & ~tm_r)) &&
      !reg_wr ##1 !reg_wr; // Flag lands one edge after the step to zero
   endsequence
   reset_vals_a: assert property ($past(reset) |-> ram_hold &&
      aux_clock_rate == 2'h0 && eq_file_index == 6'h00)
      else $error("control fields wrong after reset");
   pd_clear_a: assert property (pod_quiet ##0 reg_wr && reg_addr == 8'h00 &&
      !reg_wdata[0] |=> !ram_hold) else $error("power-down not cleared");
   tx_zero_a: assert property ($past(ram_hold) |-> tx_out == 16'h0000)
      else $error("transmit output not zero in power-down");
   aux_wr_a: assert property (pod_quiet ##0 reg_wr && reg_addr == 8'h01
      |=> {aux_clock_rate, eq_file_index} == $past(reg_wdata))
      else $error("select register write lost");
   aux_mult_a: assert property (aux_clock_mult == (aux_clock_rate == 2'h3 ?
      7'h40 : aux_clock_rate == 2'h2 ? 7'h20 : 7'h10))
      else $error("aux clock multiplier wrong");
   eq_probe_a: assert property (eq_file_index <= 6'h2f |=>
      probe_data == $past(eq_file_data)) else $error("probe not on eq file");
   all_masked_a: assert property (&{tm_r, am_r} |-> irq_n)
      else $error("request active with all masked");
   timer_irq_a: assert property (tmr_tick |=> !irq_n)
      else $error("timer expiry gave no request");
   noise_irq_a: assert property (noise_alarm_meter > noise_alarm_threshold &&
      !am_r[0] && !reg_wr |=> !irq_n) else $error("noise alarm gave no request");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   unmapped_a: assert property (reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : gcif_chk
bind global_control_and_interrupt_flags gcif_chk chk_i (
   .sys_clk, .reset, .power_on_detect, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .timer_count_is_one, .timer_count_is_zero,
   .noise_alarm_meter, .noise_alarm_threshold, .eq_file_data,
   .eq_file_index, .probe_data, .aux_clock_rate, .aux_clock_mult,
   .ram_hold, .tx_out, .irq_n
);
`default_nettype wire

// *** tb/global_control_and_interrupt_flags_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module global_control_and_interrupt_flags_test;
   logic        sys_clk, reset, power_on_detect, reg_wr, reg_rd, hold_src;
   logic        sync_detect_enable, filter_run, ram_hold, irq_n;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
   logic [7:0]  timer_count_is_one, timer_count_is_zero;
   logic [15:0] sync_accum, descrambler_sync_threshold, far_level_meter;
   logic [15:0] far_high_threshold, far_low_threshold, noise_alarm_meter;
   logic [15:0] noise_alarm_threshold, probe_data, tx_out;
   logic [15:0] src [8];
   logic [5:0]  eq_file_index;
   logic [1:0]  aux_clock_rate;
   logic [6:0]  aux_clock_mult;
   int          tm, am, tf, af, pd, aux, pr, i, j, err_total, tests_run, cyc;
   int          ac; // Alarm conditions currently present, one bit per alarm
   int          pc [10] = '{0, 47, 48, 49, 50, 51, 52, 53, 54, 63};
   host_model host (.sys_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd,
                    .reg_wdata);
   global_control_and_interrupt_flags uut (
      .sys_clk, .reset, .power_on_detect, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .timer_count_is_one, .timer_count_is_zero,
      .sync_detect_enable, .sync_accum, .descrambler_sync_threshold,
      .far_level_meter, .far_high_threshold, .far_low_threshold,
      .noise_alarm_meter, .noise_alarm_threshold, .eq_file_data(src[0]),
      .front_end_out(src[1]), .echo_replica(src[2]), .dfe_sub_out(src[3]),
      .slicer_in(src[4]), .phase_det_out(src[5]), .loop_filter_out(src[6]),
      .tx_sample(src[7]), .eq_file_index, .probe_data, .aux_clock_rate,
      .aux_clock_mult, .filter_run, .ram_hold, .tx_out, .irq_n);
   ////////////////////////////////////////////////////////////
   // Clock, fresh random datapath words each cycle unless frozen
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      for (int k = 0; k < 8; k++) if (!hold_src) src[k] <= 16'($urandom);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [15:0] seen, input int e);
      tests_run++;
      if (seen !== 16'(e)) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, 16'(e), seen);
      end
   endtask : chk
   // Behavioural register model
   function automatic int rdm(input int a);
      case (a)
         0: return 8'h1a | pd; // Revision 1, device code 5
         1: return aux * 64 + pr;
         2: return tm;
         3: return am;
         4: return tf;
         5: return af;
         default: return 0;
      endcase
   endfunction : rdm
   function automatic int irqm();
      return ((tf & ~tm & 255) | (af & ~am & 15)) == 0;
   endfunction : irqm
   task automatic mw(input int a, input int v);
      host.wr(8'(a), 8'(v));
      case (a)
         0: pd = v & 1;
         1: begin
            aux = v >> 6;
            pr = v & 63;
         end
         2: tm = v;
         3: am = v & 15;
         4: tf = tf & v;
         5: af = af & (v | ac); // A live condition keeps its flag
         default: ;
      endcase
      @(negedge sys_clk);
      chk("irq_n", irq_n, irqm());
   endtask : mw
   task automatic check_all;
      for (int a = 0; a < 8; a++) begin
         host.rd(a == 7 ? 8'hff : 8'(a), d);
         chk("reg_rdata", d, rdm(a));
      end
      chk("ram_hold", ram_hold, pd);
   endtask : check_all
   task automatic alm(input int b, input logic on);
      @(posedge sys_clk);
      ac = on ? ac | (1 << b) : ac & ~(1 << b);
      case (b)
         0: noise_alarm_meter <= on ? 16'h0200 : 16'h0010;
         1: far_level_meter <= on ? 16'h0010 : 16'h0100;
         2: far_level_meter <= on ? 16'h0300 : 16'h0100;
         default: sync_accum <= on ? 16'h0900 : 16'h0010;
      endcase
      repeat (2) @(posedge sys_clk);
   endtask : alm
   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////
   // Thresholds stay fixed; the meters move across them
   initial begin
      {reset, power_on_detect, hold_src, sync_detect_enable} = 4'h9;
      {timer_count_is_one, timer_count_is_zero} = 16'h0000;
      {sync_accum, descrambler_sync_threshold} = {16'h0010, 16'h0800};
      {far_level_meter, far_high_threshold} = {16'h0100, 16'h0200};
      {far_low_threshold, noise_alarm_meter} = {16'h0040, 16'h0010};
      noise_alarm_threshold = 16'h0100;
      pd = 1;
      aux = 0;
      pr = 0;
      tm = 255;
      am = 15;
      tf = 0;
      af = 0;
      ac = 0;
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      for (i = 0; i < 8; i++) src[i] = 16'h0000;
      i = $urandom(32'h1d30c065);
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      check_all();
      $display("test reset done");
      mw(0, 8'hfe);
      check_all();
      hold_src = 1'b1;
      for (j = 0; j < 10; j++) begin
         mw(1, (j % 4) * 64 + pc[j]);
         @(negedge sys_clk);
         chk("probe", probe_data, pc[j] < 48 ? src[0] :
            pc[j] < 54 ? src[pc[j] - 47] : 0);
         chk("mult", aux_clock_mult, aux == 3 ? 64 : aux == 2 ? 32 : 16);
         chk("tx_out", tx_out, src[7]);
      end
      mw(0, 1);
      @(negedge sys_clk);
      chk("tx_out", tx_out, 0);
      mw(0, 0);
      @(posedge sys_clk) power_on_detect <= 1'b1;
      repeat (2) @(posedge sys_clk);
      power_on_detect <= 1'b0;
      repeat (6) @(posedge sys_clk);
      pd = 1;
      aux = 0;
      pr = 0;
      check_all();
      hold_src = 1'b0;
      $display("test control done");
      for (j = 0; j < 8; j++) begin
         mw(2, j % 2 ? 255 : 255 ^ (1 << j));
         @(posedge sys_clk) timer_count_is_one <= 8'(1 << j);
         @(posedge sys_clk) timer_count_is_one <= 8'h00;
         timer_count_is_zero <= 8'(1 << j);
         repeat (2) @(posedge sys_clk);
         tf = 1 << j;
         check_all();
         mw(2, 255 ^ (1 << j));
         mw(4, 255);
         mw(2, 255);
         mw(2, 255 ^ (1 << j));
         mw(4, 255 ^ (1 << j));
         repeat (3) @(posedge sys_clk);
         check_all();
         timer_count_is_zero <= 8'h00;
      end
      $display("test timers done");
      for (j = 0; j < 4; j++) begin
         mw(3, 15 ^ (1 << j));
         alm(j, 1'b1);
         af = 1 << j;
         mw(5, 0);
         check_all();
         alm(j, 1'b0);
         af = 0;
         check_all();
         alm(j, 1'b1);
         alm(j, 1'b0);
         af = 1 << j;
         mw(5, 15);
         mw(5, 0);
         check_all();
      end
      $display("test alarms done");
      wrap_up();
   end
endmodule : global_control_and_interrupt_flags_test
`default_nettype wire
